// ### fmc_regs.sv
// Flash mode and current register pair with decoded operating controls.
// Contract
// - Mode field 00 shutdown, 01 steady light, 10 flash, 11 constant voltage.
// - Writing centre register mode bits copies them into the outer register.
// - Force voltage bit set puts the device into constant voltage operation.
// - Force voltage bit always reads back as zero.
// - Centre level is bits 5..0, resets to 010000, zero gives no current.
// - Outer level is five bits; codes at or above 10000 saturate.
// - Both levels zero turns LEDs off; voltage regulation still follows only the mode and force bit.
// - Shutdown code shuts the device down only while force bit is zero.
// - High current select chooses direct drive or high current tables.
`timescale 1ns/10ps
module fmc_regs (
  // Clock and reset
  input  wire logic              CLK_SYS,
  input  wire logic              RST,
  // Register access port
  input  wire fmc_pkg::fmc_req_s REQ,
  output logic [7:0]             RDATA,
  // Pin input
  input  wire logic              HIGH_CURRENT_SELECT,
  // Decoded controls
  output fmc_pkg::fmc_status_s   STATUS,
  output logic [5:0]             CENTRE_LED_FLASH_LEVEL,
  output logic [4:0]             OUTER_LED_FLASH_LEVEL,
  output logic                   HIGH_CURRENT_TABLE
);

  logic [1:0] mode;
  logic       force_voltage_regulation;
  logic [5:0] centre_level;
  logic [4:0] outer_level;
  logic       hcs_meta;
  logic       hcs_sync;
  logic       next_voltage;

  // Write strobe aimed at one register address.
  function automatic logic wr_hit(input fmc_pkg::fmc_req_s r, input logic [2:0] a);
    return r.wr && (r.addr == a);
  endfunction

  // The mode field is held once; both registers read the same flops so they never diverge.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      mode <= fmc_pkg::MODE_RST;
    end else if (wr_hit(REQ, fmc_pkg::ADDR_CENTRE) || wr_hit(REQ, fmc_pkg::ADDR_OUTER)) begin
      mode <= REQ.wdata[fmc_pkg::MODE_HI:fmc_pkg::MODE_LO];
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      centre_level <= fmc_pkg::CFL_RST;
    end else if (wr_hit(REQ, fmc_pkg::ADDR_CENTRE)) begin
      centre_level <= REQ.wdata[fmc_pkg::CFL_HI:0];
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      outer_level              <= fmc_pkg::OFL_RST;
      force_voltage_regulation <= 1'b0;
    end else if (wr_hit(REQ, fmc_pkg::ADDR_OUTER)) begin
      outer_level              <= REQ.wdata[fmc_pkg::OFL_HI:0];
      force_voltage_regulation <= REQ.wdata[fmc_pkg::FVR_BIT];
    end
  end

  // The select pin is asynchronous to this clock, so it is synchronised first.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      hcs_meta <= 1'b0;
      hcs_sync <= 1'b0;
    end else begin
      hcs_meta <= HIGH_CURRENT_SELECT;
      hcs_sync <= hcs_meta;
    end
  end

  always_comb begin
    next_voltage = (mode == fmc_pkg::FMC_VOLTAGE) || force_voltage_regulation;
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      // Reset reports shutdown, as the reset mode does, so the decode is one-hot from the start.
      STATUS <= '{shutdown: 1'b1, default: 1'b0};
    end else begin
      STATUS.shutdown <= (mode == fmc_pkg::FMC_SHUTDOWN) && !force_voltage_regulation;
      STATUS.steady   <= (mode == fmc_pkg::FMC_STEADY) && !force_voltage_regulation;
      STATUS.flash    <= (mode == fmc_pkg::FMC_FLASH) && !force_voltage_regulation;
      STATUS.voltage  <= next_voltage;
      STATUS.leds_off <= (centre_level == '0) && (outer_level == '0);
    end
  end

  // Saturation is applied here so the analog side only sees codes up to the top step.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      CENTRE_LED_FLASH_LEVEL <= fmc_pkg::CFL_RST;
      OUTER_LED_FLASH_LEVEL  <= fmc_pkg::OFL_RST;
      HIGH_CURRENT_TABLE     <= 1'b0;
    end else begin
      CENTRE_LED_FLASH_LEVEL <= centre_level;
      OUTER_LED_FLASH_LEVEL  <= (outer_level >= fmc_pkg::OFL_SAT) ?
                                fmc_pkg::OFL_SAT : outer_level;
      HIGH_CURRENT_TABLE     <= hcs_sync;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      RDATA <= '0;
    end else if (REQ.rd) begin
      case (REQ.addr)
        fmc_pkg::ADDR_CENTRE: RDATA <= {mode, centre_level};
        fmc_pkg::ADDR_OUTER:  RDATA <= {mode, 1'b0, outer_level};
        default:              RDATA <= '0;
      endcase
    end
  end

  property p_mirror;
    @(posedge CLK_SYS) disable iff (RST)
      (REQ.wr && REQ.addr == fmc_pkg::ADDR_CENTRE && !REQ.rd) ##1 (REQ.rd &&
      REQ.addr == fmc_pkg::ADDR_OUTER && !REQ.wr)
      |=> (RDATA[fmc_pkg::MODE_HI:fmc_pkg::MODE_LO] ==
           $past(REQ.wdata[fmc_pkg::MODE_HI:fmc_pkg::MODE_LO], 2));
  endproperty
  a_mirror: assert property (p_mirror) else $error("mode not mirrored");

  property p_force_zero;
    @(posedge CLK_SYS) disable iff (RST)
      (REQ.rd && REQ.addr == fmc_pkg::ADDR_OUTER) |=> (RDATA[fmc_pkg::FVR_BIT] == 1'b0);
  endproperty
  a_force_zero: assert property (p_force_zero) else $error("force bit read nonzero");

  property p_force_voltage;
    @(posedge CLK_SYS) disable iff (RST)
      (REQ.wr && REQ.addr == fmc_pkg::ADDR_OUTER && REQ.wdata[fmc_pkg::FVR_BIT]) ##1 !REQ.wr
      |=> (STATUS.voltage && !STATUS.shutdown);
  endproperty
  a_force_voltage: assert property (p_force_voltage) else $error("force mode ignored");

  property p_shutdown;
    @(posedge CLK_SYS) disable iff (RST)
      STATUS.shutdown |-> $past(mode) == fmc_pkg::FMC_SHUTDOWN && !$past(force_voltage_regulation);
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("bad shutdown");

  property p_decode;
    @(posedge CLK_SYS) disable iff (RST)
      $countones({STATUS.shutdown, STATUS.steady, STATUS.flash, STATUS.voltage}) == 1;
  endproperty
  a_decode: assert property (p_decode) else $error("mode decode not one-hot");

  property p_saturate;
    @(posedge CLK_SYS) disable iff (RST)
      (outer_level >= fmc_pkg::OFL_SAT) |=> (OUTER_LED_FLASH_LEVEL == fmc_pkg::OFL_SAT);
  endproperty
  a_saturate: assert property (p_saturate) else $error("outer level not saturated");

  property p_leds_off;
    @(posedge CLK_SYS) disable iff (RST)
      (centre_level == '0 && outer_level == '0) |=> STATUS.leds_off;
  endproperty
  a_leds_off: assert property (p_leds_off) else $error("leds not off");

  property p_centre;
    @(posedge CLK_SYS) disable iff (RST)
      (REQ.wr && REQ.addr == fmc_pkg::ADDR_CENTRE) ##2 !$past(REQ.wr)
      |-> CENTRE_LED_FLASH_LEVEL == $past(REQ.wdata[fmc_pkg::CFL_HI:0], 2);
  endproperty
  a_centre: assert property (p_centre) else $error("centre level wrong");

  property p_hcs;
    @(posedge CLK_SYS) disable iff (RST)
      HIGH_CURRENT_SELECT [*3] |=> HIGH_CURRENT_TABLE;
  endproperty
  a_hcs: assert property (p_hcs) else $error("high current select lost");

  property p_hcs_low;
    @(posedge CLK_SYS) disable iff (RST)
      (!HIGH_CURRENT_SELECT) [*3] |=> !HIGH_CURRENT_TABLE;
  endproperty
  a_hcs_low: assert property (p_hcs_low) else $error("direct drive select lost");

  property p_mode_read;
    @(posedge CLK_SYS) disable iff (RST)
      (REQ.rd && (REQ.addr == fmc_pkg::ADDR_CENTRE || REQ.addr == fmc_pkg::ADDR_OUTER))
      |=> (RDATA[fmc_pkg::MODE_HI:fmc_pkg::MODE_LO] == $past(mode));
  endproperty
  a_mode_read: assert property (p_mode_read) else $error("mode read back wrong");

  property p_steady;
    @(posedge CLK_SYS) disable iff (RST)
      (mode == fmc_pkg::FMC_STEADY && !force_voltage_regulation) |=> STATUS.steady;
  endproperty
  a_steady: assert property (p_steady) else $error("steady light not decoded");

  property p_flash;
    @(posedge CLK_SYS) disable iff (RST)
      (mode == fmc_pkg::FMC_FLASH && !force_voltage_regulation) |=> STATUS.flash;
  endproperty
  a_flash: assert property (p_flash) else $error("flash not decoded");

  property p_voltage_mode;
    @(posedge CLK_SYS) disable iff (RST)
      (mode == fmc_pkg::FMC_VOLTAGE) |=> STATUS.voltage;
  endproperty
  a_voltage_mode: assert property (p_voltage_mode) else $error("voltage mode not decoded");

  property p_outer_pass;
    @(posedge CLK_SYS) disable iff (RST)
      (outer_level < fmc_pkg::OFL_SAT) |=> (OUTER_LED_FLASH_LEVEL == $past(outer_level));
  endproperty
  a_outer_pass: assert property (p_outer_pass) else $error("outer level altered");

  c_flash: cover property (@(posedge CLK_SYS) disable iff (RST) STATUS.flash);
  c_steady: cover property (@(posedge CLK_SYS) disable iff (RST) STATUS.steady);
  c_off: cover property (@(posedge CLK_SYS) disable iff (RST) STATUS.leds_off);
  c_force: cover property (@(posedge CLK_SYS) disable iff (RST) STATUS.voltage);
  c_shutdown: cover property (@(posedge CLK_SYS) disable iff (RST) STATUS.shutdown);

endmodule

// ### fmc_pkg.sv
// Package with register map, field layout and types for the flash mode and current registers.
package fmc_pkg;

  localparam logic [2:0] ADDR_CENTRE = 3'h1;
  localparam logic [2:0] ADDR_OUTER  = 3'h2;

  localparam int MODE_HI   = 7;
  localparam int MODE_LO   = 6;
  localparam int FVR_BIT   = 5;
  localparam int CFL_HI    = 5;
  localparam int OFL_HI    = 4;

  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic [5:0] CFL_RST  = 6'h10;
  localparam logic [4:0] OFL_RST  = 5'h08;
  localparam logic [4:0] OFL_SAT  = 5'h10;

  typedef enum logic [1:0] {
    FMC_SHUTDOWN = 2'h0,
    FMC_STEADY   = 2'h1,
    FMC_FLASH    = 2'h2,
    FMC_VOLTAGE  = 2'h3
  } fmc_mode_e;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } fmc_req_s;

  typedef struct packed {
    logic shutdown;
    logic steady;
    logic flash;
    logic voltage;
    logic leds_off;
  } fmc_status_s;

endpackage

// ### fmc_host.sv
// Host model that issues single-byte register accesses.
`timescale 1ns/10ps
module fmc_host (
  // Clock
  input  wire logic         CLK_SYS,
  // Register access port
  output fmc_pkg::fmc_req_s REQ,
  input  wire logic [7:0]   RDATA
);
  initial REQ = '0;
  // One-cycle strobe, then two idle edges so results have settled.
  task automatic put(input logic rd, input logic [2:0] a, input logic [7:0] d);
    @(posedge CLK_SYS);
    REQ <= '{wr: !rd, rd: rd, addr: a, wdata: d};
    @(posedge CLK_SYS);
    REQ <= '0;
    @(posedge CLK_SYS);
    @(posedge CLK_SYS);
  endtask
  // Write, then read on the very next edge, to exercise back-to-back ordering.
  task automatic put_pair(input logic [2:0] wa, input logic [7:0] d, input logic [2:0] ra);
    @(posedge CLK_SYS);
    REQ <= '{wr: 1'b1, rd: 1'b0, addr: wa, wdata: d};
    @(posedge CLK_SYS);
    REQ <= '{wr: 1'b0, rd: 1'b1, addr: ra, wdata: 8'h00};
    @(posedge CLK_SYS);
    REQ <= '0;
    @(posedge CLK_SYS);
    @(posedge CLK_SYS);
  endtask
endmodule

// ### fmc_regs_test.sv
// Self-checking bench for the flash mode and current registers.
`timescale 1ns/10ps
module fmc_regs_test;
  logic                 clk_sys;
  logic                 rst;
  logic                 hcs;
  fmc_pkg::fmc_req_s    req;
  logic [7:0]           rdata;
  fmc_pkg::fmc_status_s status;
  logic [5:0]           centre;
  logic [4:0]           outer;
  logic                 tbl;
  int                   err_total = 0;
  int                   num_checks = 0;
  int                   cycles = 0;

  fmc_regs u_fmc_regs (.CLK_SYS(clk_sys), .RST(rst), .REQ(req), .RDATA(rdata),
    .HIGH_CURRENT_SELECT(hcs), .STATUS(status), .CENTRE_LED_FLASH_LEVEL(centre),
    .OUTER_LED_FLASH_LEVEL(outer), .HIGH_CURRENT_TABLE(tbl));
  fmc_host u_fmc_host (.CLK_SYS(clk_sys), .REQ(req), .RDATA(rdata));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    u_fmc_host.put(1'b0, a, d);
    #1;
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    u_fmc_host.put(1'b1, a, 8'h00);
    #1 chk("read data", rdata, exp);
  endtask

  task automatic wr_rd(input logic [2:0] wa, input logic [7:0] d, input logic [2:0] ra,
                       input logic [7:0] exp);
    u_fmc_host.put_pair(wa, d, ra);
    #1 chk("read data", rdata, exp);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // The whole run needs well under a thousand cycles.
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      err_total++;
      tally_and_finish();
    end
  end

  initial begin
    rst = 1'b1;
    hcs = 1'b0;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    #1 chk("status", 8'(status), 8'h10);
    rd(3'h1, 8'h10);
    rd(3'h2, 8'h08);
    $display("test reset done");
    for (int m = 0; m < 4; m++) begin
      wr(3'h1, {m[1:0], 6'h05});
      chk("status", 8'(status), 8'h10 >> m);
      chk("centre level", 8'(centre), 8'h05);
      rd(3'h2, {m[1:0], 6'h08});
      rd(3'h1, {m[1:0], 6'h05});
    end
    $display("test modes done");
    wr(3'h2, 8'h20);
    chk("status", 8'(status), 8'h02);
    rd(3'h2, 8'h00);
    rd(3'h1, 8'h05);
    $display("test force done");
    wr(3'h2, 8'h1F);
    chk("status", 8'(status), 8'h10);
    chk("outer level", 8'(outer), 8'h10);
    wr(3'h2, 8'h10);
    chk("outer level", 8'(outer), 8'h10);
    wr(3'h2, 8'h0F);
    chk("outer level", 8'(outer), 8'h0F);
    $display("test saturation done");
    wr(3'h1, 8'h00);
    chk("status", 8'(status), 8'h10);
    wr(3'h2, 8'h00);
    chk("status", 8'(status), 8'h11);
    wr(3'h3, 8'hFF);
    rd(3'h3, 8'h00);
    rd(3'h1, 8'h00);
    $display("test idle done");
    wr_rd(3'h1, 8'h80, 3'h2, 8'h80);
    chk("status", 8'(status), 8'h05);
    $display("test mirror done");
    @(posedge clk_sys);
    hcs <= 1'b1;
    repeat (4) @(posedge clk_sys);
    #1 chk("table", 8'(tbl), 8'h01);
    @(posedge clk_sys);
    hcs <= 1'b0;
    repeat (4) @(posedge clk_sys);
    #1 chk("table", 8'(tbl), 8'h00);
    $display("test table done");
    tally_and_finish();
  end
endmodule
